// ---- core/lpmr_bank.sv ----
// Mode register bank for addresses 05h to 1Fh
`timescale 1ns/1ps
`default_nettype none
module lpmr_bank
  import lpmr_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h5a,  // Arbitrary value
  parameter logic [7:0] REVISION_ONE = 8'h01,  // Arbitrary value
  parameter logic [7:0] REVISION_TWO = 8'h00,  // Arbitrary value
  parameter logic [3:0] DENSITY = LPMR_DENS_8GB,
  parameter logic [1:0] IO_WIDTH = 2'h0,
  parameter bit CAL_SUPPORTED = 1'b1,
  parameter bit DIV4_SUPPORTED = 1'b1,  // Must be 1 for top speed grade
  parameter bit ROWS_TOP_MISSING = 1'b0  // Set for 6Gb and 12Gb dies
)
(
  input wire logic clk_sys_i,  // System clock, 20 MHz
  input wire logic rstn_i,  // Synchronous reset, active low
  input wire logic wr_i,  // Mode write command strobe
  input wire logic rd_i,  // Mode read command strobe
  input wire logic [7:0] addr_i,  // Mode register address
  input wire logic [7:0] wdata_i,  // Mode write operand
  input wire logic cal_pin_at_supply_i,  // Calibration pin tied to rail
  output logic [7:0] rdata_o,  // Read data, registered
  output logic rvalid_o,  // Read data valid, one cycle
  output logic cal_init_o,  // Start init calibration, pulse
  output logic cal_long_o,  // Start long calibration, pulse
  output logic cal_short_o,  // Start short calibration, pulse
  output logic cal_reset_o,  // Restore default calibration, pulse
  output logic [1:0] term_strength_o,  // Data-line termination select
  output logic term_in_powerdown_o,  // Keep termination in power down
  output logic [7:0] bank_mask_o,  // Self refresh bank mask
  output logic [7:0] segment_mask_o  // Effective segment mask
);
  typedef struct packed {
    logic [7:0] rdata;
    logic rvalid;
    logic [3:0] cal_pulse;
    logic [2:0] term;
    logic [7:0] bank_mask;
    logic [7:0] seg_mask;
  } lpmr_state_type;

  lpmr_state_type state;
  lpmr_state_type next_state;
  lpmr_cal_type cal_cmd;
  logic cal_strobe;
  logic cal_any;

  function automatic logic is_reserved(input logic [7:0] a);
    is_reserved = (a >= LPMR_ADDR_RSVD_A_LO && a <= LPMR_ADDR_RSVD_A_HI)
               || (a >= LPMR_ADDR_RSVD_B_LO && a <= LPMR_ADDR_RSVD_B_HI);
  endfunction

  function automatic logic [7:0] config_value();
    logic [7:0] v;
    v = 8'h00;
    v[LPMR_TYPE_LSB +: 2] = LPMR_TYPE_PREFETCH8;
    v[LPMR_DENS_LSB +: 4] = DENSITY;
    v[LPMR_WIDTH_LSB +: 2] = IO_WIDTH;
    return v;
  endfunction

  assign cal_strobe = wr_i && (addr_i == LPMR_ADDR_CAL);
  assign cal_any = |state.cal_pulse;

  lpmr_cal_decode u_cal_decode (
    .code_i(wdata_i),
    .strobe_i(cal_strobe),
    .cal_enable_i(CAL_SUPPORTED && !cal_pin_at_supply_i),
    .cmd_o(cal_cmd)
  );

  always_comb begin
    next_state = state;
    next_state.rvalid = 1'b0;
    next_state.cal_pulse = 4'h0;
    case (cal_cmd)
      LPMR_CAL_DO_INIT: next_state.cal_pulse[0] = 1'b1;
      LPMR_CAL_DO_LONG: next_state.cal_pulse[1] = 1'b1;
      LPMR_CAL_DO_SHORT: next_state.cal_pulse[2] = 1'b1;
      LPMR_CAL_DO_RESET: next_state.cal_pulse[3] = 1'b1;
      default: next_state.cal_pulse = 4'h0;
    endcase
    if (wr_i) begin
      case (addr_i)
        LPMR_ADDR_TERM: begin
          // Reserved high bits are dropped
          next_state.term = wdata_i[2:0];
          if (!DIV4_SUPPORTED && wdata_i[1:0] == LPMR_TERM_DIV4) begin
            next_state.term[1:0] = state.term[1:0];
          end
        end
        LPMR_ADDR_BANK_MASK: next_state.bank_mask = wdata_i;
        LPMR_ADDR_SEG_MASK: next_state.seg_mask = wdata_i;
        default: next_state.term = state.term;
      endcase
    end
    if (rd_i) begin
      next_state.rvalid = 1'b1;
      // Write-only, test and reserved addresses read as zero
      case (addr_i)
        LPMR_ADDR_MAKER: next_state.rdata = MAKER_CODE;
        LPMR_ADDR_REV_ONE: next_state.rdata = REVISION_ONE;
        LPMR_ADDR_REV_TWO: next_state.rdata = REVISION_TWO;
        LPMR_ADDR_CONFIG: next_state.rdata = config_value();
        LPMR_ADDR_VTEST: next_state.rdata = LPMR_READ_IDLE;
        default: next_state.rdata = LPMR_READ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      state.rdata <= LPMR_READ_IDLE;
      state.rvalid <= 1'b0;
      state.cal_pulse <= 4'h0;
      state.term <= LPMR_TERM_RESET;
      state.bank_mask <= LPMR_MASK_RESET;
      state.seg_mask <= LPMR_MASK_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign rdata_o = state.rdata;
  assign rvalid_o = state.rvalid;
  assign cal_init_o = state.cal_pulse[0];
  assign cal_long_o = state.cal_pulse[1];
  assign cal_short_o = state.cal_pulse[2];
  assign cal_reset_o = state.cal_pulse[3];
  assign term_strength_o = state.term[1:0];
  assign term_in_powerdown_o = state.term[LPMR_TERM_PD_BIT];
  assign bank_mask_o = state.bank_mask;
  // Absent rows make the top two segments meaningless
  assign segment_mask_o = ROWS_TOP_MISSING ?
    {2'b00, state.seg_mask[5:0]} : state.seg_mask;

  maker_read_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    rd_i && addr_i == LPMR_ADDR_MAKER |=> rvalid_o && rdata_o == MAKER_CODE)
    else $error("maker code read wrong");
  rev_one_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    rd_i && addr_i == LPMR_ADDR_REV_ONE |=> rdata_o == REVISION_ONE)
    else $error("revision one read wrong");
  rev_two_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    rd_i && addr_i == LPMR_ADDR_REV_TWO |=> rdata_o == REVISION_TWO)
    else $error("revision two read wrong");
  config_type_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    rd_i && addr_i == LPMR_ADDR_CONFIG |=> rdata_o[1:0] == 2'h3
    && rdata_o[5:2] == DENSITY && rdata_o[7:6] == IO_WIDTH)
    else $error("config read wrong");
  cal_start_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    wr_i && addr_i == LPMR_ADDR_CAL && wdata_i == 8'hab
    && CAL_SUPPORTED && !cal_pin_at_supply_i |=> cal_long_o ##1 !cal_long_o)
    else $error("long calibration not pulsed");
  cal_ignore_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    cal_pin_at_supply_i |=> !$past(cal_pin_at_supply_i)
    || !(cal_init_o || cal_long_o || cal_short_o || cal_reset_o))
    else $error("calibration not ignored");
  cal_reserved_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    wr_i && addr_i == LPMR_ADDR_CAL && wdata_i == 8'h00 |=>
    !(cal_init_o || cal_long_o || cal_short_o || cal_reset_o))
    else $error("reserved calibration code acted");
  term_write_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    wr_i && addr_i == LPMR_ADDR_TERM |=>
    term_in_powerdown_o == $past(wdata_i[2]))
    else $error("termination write lost");
  mask_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    wr_i && is_reserved(addr_i) |=> $stable(bank_mask_o)
    && $stable(segment_mask_o) && $stable(term_strength_o))
    else $error("reserved write changed state");
  bank_write_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    wr_i && addr_i == LPMR_ADDR_BANK_MASK |=> bank_mask_o == $past(wdata_i))
    else $error("bank mask write lost");

  rvalid_set_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    rd_i |=> rvalid_o)
    else $error("read not answered");

  rvalid_clear_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !rd_i |=> !rvalid_o)
    else $error("read valid without read");

  density_read_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    rd_i && addr_i == LPMR_ADDR_CONFIG |=> rdata_o[5:2] == DENSITY)
    else $error("density field wrong");

  width_read_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    rd_i && addr_i == LPMR_ADDR_CONFIG |=> rdata_o[7:6] == IO_WIDTH)
    else $error("width field wrong");

  vtest_read_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    rd_i && addr_i == LPMR_ADDR_VTEST |=> rdata_o == LPMR_READ_IDLE)
    else $error("test register read not idle");

  cal_init_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    wr_i && addr_i == LPMR_ADDR_CAL && wdata_i == LPMR_CAL_INIT
    && CAL_SUPPORTED && !cal_pin_at_supply_i |=> cal_init_o)
    else $error("init calibration not pulsed");

  cal_short_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    wr_i && addr_i == LPMR_ADDR_CAL && wdata_i == LPMR_CAL_SHORT
    && CAL_SUPPORTED && !cal_pin_at_supply_i |=> cal_short_o)
    else $error("short calibration not pulsed");

  cal_reset_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    wr_i && addr_i == LPMR_ADDR_CAL && wdata_i == LPMR_CAL_RESET
    && CAL_SUPPORTED && !cal_pin_at_supply_i |=> cal_reset_o)
    else $error("calibration reset not pulsed");

  cal_onehot_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $onehot0({cal_init_o, cal_long_o, cal_short_o, cal_reset_o}))
    else $error("several calibrations at once");

  cal_idle_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !(wr_i && addr_i == LPMR_ADDR_CAL) |=> !cal_any)
    else $error("calibration without command");

  cal_pin_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    wr_i && cal_pin_at_supply_i |=> !cal_any)
    else $error("strapped pin did not block");

  cal_unsup_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !CAL_SUPPORTED |-> !cal_any)
    else $error("unsupported calibration acted");

  term_strength_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    wr_i && addr_i == LPMR_ADDR_TERM && DIV4_SUPPORTED |=>
    term_strength_o == $past(wdata_i[1:0]))
    else $error("termination strength lost");

  div4_keep_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    wr_i && addr_i == LPMR_ADDR_TERM && !DIV4_SUPPORTED
    && wdata_i[1:0] == LPMR_TERM_DIV4 |=> $stable(term_strength_o))
    else $error("unsupported divide taken");

  term_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !(wr_i && addr_i == LPMR_ADDR_TERM) |=> $stable(term_strength_o)
    && $stable(term_in_powerdown_o))
    else $error("termination changed unasked");

  bank_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !(wr_i && addr_i == LPMR_ADDR_BANK_MASK) |=> $stable(bank_mask_o))
    else $error("bank mask changed unasked");

  seg_write_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    wr_i && addr_i == LPMR_ADDR_SEG_MASK |=>
    segment_mask_o[5:0] == $past(wdata_i[5:0]))
    else $error("segment mask write lost");

  seg_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !(wr_i && addr_i == LPMR_ADDR_SEG_MASK) |=> $stable(segment_mask_o))
    else $error("segment mask changed unasked");

  seg_full_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    wr_i && addr_i == LPMR_ADDR_SEG_MASK && !ROWS_TOP_MISSING |=>
    segment_mask_o == $past(wdata_i))
    else $error("top segment bits lost");

  seg_top_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ROWS_TOP_MISSING |-> segment_mask_o[7:6] == 2'b00)
    else $error("absent segments not ignored");

  rsvd_read_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    rd_i && is_reserved(addr_i) |=> rdata_o == LPMR_READ_IDLE)
    else $error("reserved read not idle");

  ro_write_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    wr_i && addr_i >= LPMR_ADDR_MAKER && addr_i <= LPMR_ADDR_VTEST |=>
    $stable(bank_mask_o) && $stable(segment_mask_o)
    && $stable(term_strength_o) && $stable(term_in_powerdown_o))
    else $error("read-only write changed state");

  rdata_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !rd_i |=> $stable(rdata_o))
    else $error("read data moved without read");
endmodule
`default_nettype wire

// ---- core/lpmr_cal_decode.sv ----
// Calibration command decoder with pin strap and support gating
`timescale 1ns/1ps
`default_nettype none
module lpmr_cal_decode
  import lpmr_pkg::*;
(
  input wire logic [7:0] code_i,  // Written calibration code
  input wire logic strobe_i,  // Write to calibration register
  input wire logic cal_enable_i,  // Calibration usable
  output var lpmr_cal_type cmd_o  // Decoded command, NONE if ignored
);
  always_comb begin
    cmd_o = LPMR_CAL_NONE;
    if (strobe_i && cal_enable_i) begin
      case (code_i)
        LPMR_CAL_INIT: cmd_o = LPMR_CAL_DO_INIT;
        LPMR_CAL_LONG: cmd_o = LPMR_CAL_DO_LONG;
        LPMR_CAL_SHORT: cmd_o = LPMR_CAL_DO_SHORT;
        LPMR_CAL_RESET: cmd_o = LPMR_CAL_DO_RESET;
        default: cmd_o = LPMR_CAL_NONE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- core/lpmr_pkg.sv ----
// Package: constants for the mode register bank, addresses 05h to 1Fh
package lpmr_pkg;
  localparam logic [7:0] LPMR_ADDR_MAKER = 8'h05;
  localparam logic [7:0] LPMR_ADDR_REV_ONE = 8'h06;
  localparam logic [7:0] LPMR_ADDR_REV_TWO = 8'h07;
  localparam logic [7:0] LPMR_ADDR_CONFIG = 8'h08;
  localparam logic [7:0] LPMR_ADDR_VTEST = 8'h09;
  localparam logic [7:0] LPMR_ADDR_CAL = 8'h0a;
  localparam logic [7:0] LPMR_ADDR_TERM = 8'h0b;
  localparam logic [7:0] LPMR_ADDR_BANK_MASK = 8'h10;
  localparam logic [7:0] LPMR_ADDR_SEG_MASK = 8'h11;
  localparam logic [7:0] LPMR_ADDR_RSVD_A_LO = 8'h0c;
  localparam logic [7:0] LPMR_ADDR_RSVD_A_HI = 8'h0f;
  localparam logic [7:0] LPMR_ADDR_RSVD_B_LO = 8'h12;
  localparam logic [7:0] LPMR_ADDR_RSVD_B_HI = 8'h1f;
  // Calibration command codes
  localparam logic [7:0] LPMR_CAL_INIT = 8'hff;
  localparam logic [7:0] LPMR_CAL_LONG = 8'hab;
  localparam logic [7:0] LPMR_CAL_SHORT = 8'h56;
  localparam logic [7:0] LPMR_CAL_RESET = 8'hc3;
  // Config register fields
  localparam int LPMR_TYPE_LSB = 0;
  localparam int LPMR_DENS_LSB = 2;
  localparam int LPMR_WIDTH_LSB = 6;
  localparam logic [1:0] LPMR_TYPE_PREFETCH8 = 2'h3;
  localparam logic [3:0] LPMR_DENS_4GB = 4'h6;
  localparam logic [3:0] LPMR_DENS_6GB = 4'he;
  localparam logic [3:0] LPMR_DENS_8GB = 4'h7;
  // Termination register fields
  localparam int LPMR_TERM_PD_BIT = 2;
  localparam logic [1:0] LPMR_TERM_OFF = 2'h0;
  localparam logic [1:0] LPMR_TERM_DIV4 = 2'h1;
  localparam logic [1:0] LPMR_TERM_DIV2 = 2'h2;
  localparam logic [1:0] LPMR_TERM_DIV1 = 2'h3;
  // Reset values
  localparam logic [2:0] LPMR_TERM_RESET = 3'h0;
  localparam logic [7:0] LPMR_MASK_RESET = 8'h00;
  localparam logic [7:0] LPMR_READ_IDLE = 8'h00;

  typedef enum logic [2:0] {
    LPMR_CAL_NONE,
    LPMR_CAL_DO_INIT,
    LPMR_CAL_DO_LONG,
    LPMR_CAL_DO_SHORT,
    LPMR_CAL_DO_RESET
  } lpmr_cal_type;
endpackage

// ---- dv/lpmr_bank_tb_top.sv ----
// Testbench for the mode register bank, normal and reduced die variants
`timescale 1ns/1ps
`default_nettype none
module lpmr_bank_tb_top;
  import lpmr_pkg::*;
  typedef struct {
    logic [7:0] a, d;
    logic [3:0] cal;
    logic [2:0] term;
    logic [7:0] bank, seg;
  } lpmr_row_type;
  logic clk_sys_i, rstn_i, cal_pin, wr, rd;
  logic [7:0] addr, wdata;
  logic [7:0] rdata [2], bank [2], seg [2];
  logic rvalid [2], ci [2], cl [2], cs [2], cr [2], tpd [2];
  logic [1:0] term [2];
  int miscompares = 0;
  int checked = 0;
  lpmr_row_type rows [15] = '{
    '{8'h0a, 8'hff, 4'h8, 3'h0, 8'h00, 8'h00},
    '{8'h0a, 8'hab, 4'h4, 3'h0, 8'h00, 8'h00},
    '{8'h0a, 8'h56, 4'h2, 3'h0, 8'h00, 8'h00},
    '{8'h0a, 8'hc3, 4'h1, 3'h0, 8'h00, 8'h00},
    '{8'h0a, 8'h00, 4'h0, 3'h0, 8'h00, 8'h00},
    '{8'h0b, 8'hff, 4'h0, 3'h7, 8'h00, 8'h00},
    '{8'h0b, 8'h01, 4'h0, 3'h1, 8'h00, 8'h00},
    '{8'h0b, 8'h06, 4'h0, 3'h6, 8'h00, 8'h00},
    '{8'h10, 8'ha5, 4'h0, 3'h6, 8'ha5, 8'h00},
    '{8'h11, 8'hc3, 4'h0, 3'h6, 8'ha5, 8'hc3},
    '{8'h05, 8'hff, 4'h0, 3'h6, 8'ha5, 8'hc3},
    '{8'h09, 8'hff, 4'h0, 3'h6, 8'ha5, 8'hc3},
    '{8'h0c, 8'hff, 4'h0, 3'h6, 8'ha5, 8'hc3},
    '{8'h12, 8'hff, 4'h0, 3'h6, 8'ha5, 8'hc3},
    '{8'h1f, 8'hff, 4'h0, 3'h6, 8'ha5, 8'hc3}};
  logic [7:0] ra [8] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h10,
    8'h1f};
  logic [7:0] re [8] = '{8'h5a, 8'h01, 8'h00, 8'h1f, 8'h00, 8'h00, 8'h00,
    8'h00};
  lpmr_host_model host (.clk_sys_i(clk_sys_i), .wr_o(wr), .rd_o(rd),
    .addr_o(addr), .wdata_o(wdata));
  // Instance 1 is a 6Gb die without calibration or divide-by-four
  for (genvar i = 0; i < 2; i++) begin : g
    lpmr_bank #(.DENSITY(i ? LPMR_DENS_6GB : LPMR_DENS_8GB),
      .CAL_SUPPORTED(i == 0), .DIV4_SUPPORTED(i == 0),
      .ROWS_TOP_MISSING(i == 1)) DUT (
      .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .wr_i(wr), .rd_i(rd),
      .addr_i(addr), .wdata_i(wdata), .cal_pin_at_supply_i(cal_pin),
      .rdata_o(rdata[i]), .rvalid_o(rvalid[i]), .cal_init_o(ci[i]),
      .cal_long_o(cl[i]), .cal_short_o(cs[i]), .cal_reset_o(cr[i]),
      .term_strength_o(term[i]), .term_in_powerdown_o(tpd[i]),
      .bank_mask_o(bank[i]), .segment_mask_o(seg[i]));
  end
  task automatic chk(string n, logic [7:0] got, exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    repeat (1000) @(posedge clk_sys_i);
    miscompares++;
    end_sim();
  end
  initial begin
    rstn_i = 1'b0;
    cal_pin = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    foreach (rows[i]) begin
      host.access(1'b1, rows[i].a, rows[i].d);
      #1;
      chk("cal", {ci[0], cl[0], cs[0], cr[0]}, rows[i].cal);
      chk("cal_alt", {ci[1], cl[1], cs[1], cr[1]}, 8'h00);
      chk("term", {tpd[0], term[0]}, rows[i].term);
      chk("bank", bank[0], rows[i].bank);
      chk("seg", seg[0], rows[i].seg);
    end
    chk("seg_alt", seg[1], 8'h03);
    host.access(1'b1, 8'h0b, 8'h01);
    #1;
    chk("term_alt", {tpd[1], term[1]}, 8'h02);
    foreach (ra[i]) begin
      host.access(1'b0, ra[i], 8'h00);
      #1;
      chk("rdata", rdata[0], re[i]);
      chk("rvalid", rvalid[0], 8'h01);
    end
    host.access(1'b0, 8'h08, 8'h00);
    #1;
    chk("cfg_alt", rdata[1], 8'h3b);
    @(posedge clk_sys_i);
    cal_pin <= 1'b1;
    #1;
    chk("rvalid_end", rvalid[0], 8'h00);
    host.access(1'b1, 8'h0a, 8'hff);
    #1;
    chk("cal_pin", {ci[0], cl[0], cs[0], cr[0]}, 8'h00);
    @(posedge clk_sys_i);
    rstn_i <= 1'b0;
    @(posedge clk_sys_i);
    #1;
    chk("rst_term", {tpd[0], term[0]}, 8'h00);
    chk("rst_bank", bank[0], 8'h00);
    chk("rst_seg", seg[0], 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire

// ---- dv/lpmr_host_model.sv ----
// Host controller model issuing mode writes and reads
`timescale 1ns/1ps
`default_nettype none
module lpmr_host_model (
  input wire logic clk_sys_i,  // System clock
  output logic wr_o,  // Mode write strobe
  output logic rd_o,  // Mode read strobe
  output logic [7:0] addr_o,  // Mode register address
  output logic [7:0] wdata_o  // Write operand
);
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  // One-cycle request; released address and data lines show the inverse, never stale data; strobes drop low
  task automatic access(input logic w, input logic [7:0] a, d);
    @(posedge clk_sys_i);
    wr_o <= w;
    rd_o <= !w;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_sys_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
endmodule
`default_nettype wire
